// [common/wed_pkg.sv]
package wed_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_STATUS = 8;
  localparam int NUM_GPIO = 22;
  localparam int IDX_W = 3;

  // Status register indices
  localparam logic [IDX_W-1:0] IDX_GENERAL = 3'h0;
  localparam logic [IDX_W-1:0] IDX_FIRST = 3'h1;
  localparam logic [IDX_W-1:0] IDX_SECOND = 3'h2;
  localparam logic [IDX_W-1:0] IDX_HOST = 3'h3;
  localparam logic [IDX_W-1:0] IDX_FOURTH = 3'h4;
  localparam logic [IDX_W-1:0] IDX_FIFTH = 3'h5;
  localparam logic [IDX_W-1:0] IDX_SIXTH = 3'h6;
  localparam logic [IDX_W-1:0] IDX_FAN = 3'h7;

  localparam logic [ADDR_W-1:0] OFF_GENERAL_STATUS = 16'h7f02;
  localparam logic [ADDR_W-1:0] OFF_FIRST_STATUS = 16'h7f2a;
  localparam logic [ADDR_W-1:0] OFF_SECOND_STATUS = 16'h7f2b;
  localparam logic [ADDR_W-1:0] OFF_HOST_STATUS = 16'h7f55;
  localparam logic [ADDR_W-1:0] OFF_FOURTH_STATUS = 16'h7f59;
  localparam logic [ADDR_W-1:0] OFF_FIFTH_STATUS = 16'h7f5e;
  localparam logic [ADDR_W-1:0] OFF_SIXTH_STATUS = 16'h7f63;
  localparam logic [ADDR_W-1:0] OFF_FAN_STATUS = 16'h7f64;

  // Mask registers sit at base plus status index
  localparam logic [ADDR_W-1:0] OFF_MASK_BASE = 16'h7f80;
  // Edge configuration, three bytes each, gpio 0 in the low byte
  localparam logic [ADDR_W-1:0] OFF_ANY_EDGE_BASE = 16'h7f88;
  localparam logic [ADDR_W-1:0] OFF_POLARITY_BASE = 16'h7f8b;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_CTRL = 16'h7f8e;

  localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] RST_MASK = 8'hff;
  localparam logic [DATA_W-1:0] RST_ANY_EDGE = 8'hff;
  localparam logic [DATA_W-1:0] RST_POLARITY = 8'h00;

  // Sleep control fields
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_OSC_OFF_BIT = 1;
  localparam int CTRL_PENDING_BIT = 2;

  // First register
  localparam int B_BUS_TWO = 3;
  localparam int B_BUS_ONE = 4;
  localparam int B_PWR_STATUS = 5;
  localparam int B_PWR_ENABLE = 6;
  localparam int B_PWR_CONTROL = 7;
  // Second register
  localparam int B_ALARM = 0;
  localparam int B_ANY_KEY = 1;
  localparam int B_HIB_IR = 2;
  localparam int B_GEN_WAKEUP = 3;
  localparam int B_IN1 = 4;
  localparam int B_IN0_IN2 = 5;
  localparam int B_RING = 6;
  // General input register
  localparam int B_GPIO3 = 3;
  // Fan register; B_SECOND_IR is bit 2 of the fifth register
  localparam int B_FAN_ONE = 0;
  localparam int B_FAN_TWO = 1;
  localparam int B_FLOPPY = 2;
  localparam int B_SECOND_IR = 2;

  typedef enum logic [1:0] {
    WED_AWAKE  = 2'b00,
    WED_ASLEEP = 2'b01,
    WED_WAKING = 2'b10
  } wed_sleep_e;

endpackage

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic         core_clk;
  logic         resetn;
  logic [15:0]  reg_addr;
  logic [7:0]   reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  logic         cpu_sleeping;
  logic         ring_osc_en;
  logic         wake_pending;
  logic [102:0] lv;
  logic [7:0]   d;
  logic [7:0]   m;
  logic [15:0]  a;
  int           n_errors;
  int           check_count;
  int           cycles;

  // Source index, status address low byte, bit, either-edge flag
  localparam logic [23:0] TBL [23] = '{
    24'h002b00, 24'h012b20, 24'h022a50, 24'h032a60, 24'h042a70, 24'h052b60,
    24'h062a40, 24'h072a30, 24'h082b20, 24'h0c2b10, 24'h306400, 24'h316410,
    24'h326421, 24'h335501, 24'h3a5571, 24'h2f5e20, 24'h142b30, 24'h122b41,
    24'h112b51, 24'h195921, 24'h1a5931, 24'h276301, 24'h1c0231};
  localparam logic [7:0] STS [8] = '{8'h02, 8'h2a, 8'h2b, 8'h55, 8'h59, 8'h5e, 8'h63, 8'h64};

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  wed_pin_model pins (.core_clk(core_clk), .lv(lv));

  wed_top i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_alarm_wake(lv[0]), .hibernation_timer_wake(lv[1]), .power_status_wake(lv[2]),
    .power_enable_wake(lv[3]), .power_control_wake(lv[4]), .ring_indicator_pin(lv[5]),
    .two_wire_bus_one_data(lv[6]), .two_wire_bus_two_data(lv[7]),
    .infrared_receive_pin(lv[8]), .key_scan_inputs(lv[16:9]), .general_inputs(lv[24:17]),
    .gpio_pins(lv[46:25]), .gpio_alt_sel(lv[80:59]), .gpio_alt_in(lv[102:81]),
    .second_infrared_detect(lv[47]), .fan_speed_one_low(lv[48]), .fan_speed_two_low(lv[49]),
    .floppy_parallel_detect(lv[50]), .host_gpio_pins(lv[58:51]),
    .cpu_sleeping(cpu_sleeping), .ring_osc_en(ring_osc_en), .wake_pending(wake_pending)
  );

  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] ad, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 760 cycles; a hang stops well after that
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    resetn      = 1'b0;
    reg_addr    = 16'h0000;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    n_errors    = 0;
    check_count = 0;
    cycles      = 0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    idle(3);

    for (int i = 0; i < 8; i++) begin
      rd({8'h7f, STS[i]}, d);
      chk("status reset", wed_pkg::RST_STATUS, d);
      rd(wed_pkg::OFF_MASK_BASE + 16'(i), d);
      chk("mask reset", wed_pkg::RST_MASK, d);
    end
    wr(16'h7f00, 8'hff);
    rd(16'h7f00, d);
    chk("unmapped", 8'h00, d);
    rd(wed_pkg::OFF_ANY_EDGE_BASE + 16'h0002, d);
    chk("edge cfg reset", wed_pkg::RST_ANY_EDGE, d);
    rd(wed_pkg::OFF_POLARITY_BASE + 16'h0002, d);
    chk("polarity reset", wed_pkg::RST_POLARITY, d);
    $display("test reset done");

    // Masked sources still record; either-edge ones fire again on the way back
    for (int k = 0; k < 23; k++) begin
      a = {8'h7f, TBL[k][15:8]};
      m = 8'h01 << TBL[k][7:4];
      pins.flip(int'(TBL[k][23:16]));
      idle(6);
      rd(a, d);
      chk("event bit", m, d);
      wr(a, 8'h00);
      rd(a, d);
      chk("status held", m, d);
      wr(a, m);
      pins.flip(int'(TBL[k][23:16]));
      idle(6);
      rd(a, d);
      chk("return edge", TBL[k][0] ? m : 8'h00, d);
      wr(a, m);
    end
    $display("test events done");

    wr(wed_pkg::OFF_ANY_EDGE_BASE, 8'hfe);
    for (int p = 1; p >= 0; p--) begin
      wr(wed_pkg::OFF_POLARITY_BASE, 8'(p));
      rd(wed_pkg::OFF_POLARITY_BASE, d);
      chk("polarity readback", 8'(p), d);
      pins.flip(25);
      idle(6);
      rd(wed_pkg::OFF_FOURTH_STATUS, d);
      chk("rising gpio", (p == 1) ? 8'h04 : 8'h00, d);
      wr(wed_pkg::OFF_FOURTH_STATUS, 8'h04);
      pins.flip(25);
      idle(6);
      rd(wed_pkg::OFF_FOURTH_STATUS, d);
      chk("falling gpio", (p == 1) ? 8'h00 : 8'h04, d);
      wr(wed_pkg::OFF_FOURTH_STATUS, 8'h04);
    end
    wr(wed_pkg::OFF_ANY_EDGE_BASE, 8'hff);
    pins.flip(60);
    pins.flip(82);
    idle(6);
    rd(wed_pkg::OFF_FOURTH_STATUS, d);
    chk("alternate input", 8'h08, d);
    pins.flip(82);
    pins.flip(60);
    idle(6);
    wr(wed_pkg::OFF_FOURTH_STATUS, 8'hff);
    $display("test edge select done");

    // Only the any-key bit is unmasked, so the fan event must not wake
    wr(wed_pkg::OFF_MASK_BASE + 16'(wed_pkg::IDX_SECOND), 8'hfd);
    wr(wed_pkg::OFF_SLEEP_CTRL, 8'h01);
    idle(2);
    chk("asleep", 8'h01, {7'h00, cpu_sleeping});
    pins.flip(48);
    idle(8);
    chk("masked stays asleep", 8'h01, {6'h00, ring_osc_en, cpu_sleeping});
    pins.flip(12);
    idle(4);
    chk("woken", 8'h02, {6'h00, ring_osc_en, cpu_sleeping});
    rd(wed_pkg::OFF_SLEEP_CTRL, d);
    chk("control read", 8'h06, d);
    wr(wed_pkg::OFF_SLEEP_CTRL, 8'h02);
    idle(2);
    chk("oscillator off", 8'h00, {7'h00, ring_osc_en});
    pins.flip(12);
    pins.flip(48);
    wr(wed_pkg::OFF_SECOND_STATUS, 8'h02);
    wr(wed_pkg::OFF_FAN_STATUS, 8'h01);
    rd(wed_pkg::OFF_SLEEP_CTRL, d);
    chk("nothing pending", 8'h00, d);
    $display("test sleep done");
    summarize();
  end
endmodule

// [dv/wed_pin_model.sv]
`timescale 1ns/1ps
// Far side: wake pins and on-chip event levels, packed one bit per source
// 0..4 internal, 5 ring, 6..7 bus data, 8 infrared, 9..16 key scan, 17..24 general inputs,
// 25..46 gpio, 47 second infrared, 48..49 fan, 50 floppy, 51..58 host gpio,
// 59..80 alternate select, 81..102 alternate input
module wed_pin_model (
  input  wire logic         core_clk,
  output logic      [102:0] lv
);
  // Falling-edge sources idle high so their first move is the active one
  localparam logic [102:0] IDLE = (103'hf << 5) | (103'hff << 9) | (103'h1 << 20);

  initial lv = IDLE;

  // Moves one source just after an edge, like a real pin synchronous to the clock
  task automatic flip(input int i);
    @(posedge core_clk);
    lv[i] <= ~lv[i];
  endtask
endmodule

// [dv/wed_top_props.sv]
`timescale 1ns/1ps
module wed_top_props (
  input wire logic                       core_clk,
  input wire logic                       resetn,
  input wire logic [wed_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wed_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [wed_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       cpu_sleeping,
  input wire logic                       ring_osc_en,
  input wire logic                       wake_pending
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic ctrl_wr;
  assign ctrl_wr = reg_wr && (reg_addr == wed_pkg::OFF_SLEEP_CTRL);

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  sleep_hold_a: assert property (cpu_sleeping && !wake_pending |=>
    cpu_sleeping && !ring_osc_en)
    else $error("left sleep without an unmasked event");
  wake_start_a: assert property (cpu_sleeping && wake_pending |=>
    ring_osc_en && !cpu_sleeping)
    else $error("unmasked event did not start the oscillator");
  osc_cause_a: assert property ($rose(ring_osc_en) |->
    $past(cpu_sleeping) && $past(wake_pending))
    else $error("oscillator started without a sleeping cause");
  pending_hold_a: assert property (wake_pending && !reg_wr |=> wake_pending)
    else $error("pending event vanished without a write");
  osc_hold_a: assert property (ring_osc_en && !(ctrl_wr && reg_wdata[1]) |=> ring_osc_en)
    else $error("oscillator stopped without an off command");
  sleep_entry_a: assert property (ctrl_wr && reg_wdata[0] &&
    !cpu_sleeping && !ring_osc_en |=> cpu_sleeping)
    else $error("sleep command not taken while awake");
  ctrl_read_a: assert property (reg_rd && reg_addr == wed_pkg::OFF_SLEEP_CTRL |=>
    reg_rdata[2:0] == {$past(wake_pending), $past(ring_osc_en), $past(cpu_sleeping)})
    else $error("control read does not show the sleep state");

  sleep_seen_c: cover property ($rose(cpu_sleeping));
  wake_seen_c: cover property ($rose(ring_osc_en));
  pending_seen_c: cover property ($rose(wake_pending));
endmodule

bind wed_top wed_top_props i_props (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleeping(cpu_sleeping),
  .ring_osc_en(ring_osc_en), .wake_pending(wake_pending)
);

// [hw/wed_edge_det.sv]
`timescale 1ns/1ps
// Per-bit edge detector: any edge, or rising when rise_sel else falling
module wed_edge_det #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] sample,
  input  wire logic [WIDTH-1:0] any_edge,
  input  wire logic [WIDTH-1:0] rise_sel,
  output logic      [WIDTH-1:0] hit
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;
  logic             armed;
  logic             next_armed;

  // First sample after reset only primes history, no false edge
  always_comb begin
    next_prev = sample;
    next_armed = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      armed <= 1'b0;
    end else begin
      prev <= next_prev;
      armed <= next_armed;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        if (!armed) begin
          hit[i] = 1'b0;
        end else if (any_edge[i]) begin
          hit[i] = sample[i] ^ prev[i];
        end else if (rise_sel[i]) begin
          hit[i] = sample[i] & ~prev[i];
        end else begin
          hit[i] = ~sample[i] & prev[i];
        end
      end
    end
  endgenerate

endmodule

// [hw/wed_top.sv]
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// Wake event detector, standby domain; core_clk is the always-running clock
module wed_top (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic [wed_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [wed_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [wed_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic                          clock_alarm_wake,
  input  wire logic                          hibernation_timer_wake,
  input  wire logic                          power_status_wake,
  input  wire logic                          power_enable_wake,
  input  wire logic                          power_control_wake,
  input  wire logic                          ring_indicator_pin,
  input  wire logic                          two_wire_bus_one_data,
  input  wire logic                          two_wire_bus_two_data,
  input  wire logic                          infrared_receive_pin,
  input  wire logic [7:0]                    key_scan_inputs,
  input  wire logic [7:0]                    general_inputs,
  input  wire logic [wed_pkg::NUM_GPIO-1:0]  gpio_pins,
  input  wire logic [wed_pkg::NUM_GPIO-1:0]  gpio_alt_sel,
  input  wire logic [wed_pkg::NUM_GPIO-1:0]  gpio_alt_in,
  input  wire logic                          second_infrared_detect,
  input  wire logic                          fan_speed_one_low,
  input  wire logic                          fan_speed_two_low,
  input  wire logic                          floppy_parallel_detect,
  input  wire logic [7:0]                    host_gpio_pins,
  output logic                               cpu_sleeping,
  output logic                               ring_osc_en,
  output logic                               wake_pending
);

  localparam int NG = wed_pkg::NUM_GPIO;
  localparam int NE = 16;
  localparam int NL = 8;
  localparam int NR = 24;

  // Address decode shared by read and write paths
  function automatic logic [4:0] decode(input logic [wed_pkg::ADDR_W-1:0] a);
    logic [4:0] r;
    // Unmapped addresses land on 5'h1f, which no register uses
    r = 5'h1f;
    if (a == wed_pkg::OFF_GENERAL_STATUS) begin
      r = {2'b00, wed_pkg::IDX_GENERAL};
    end else if (a == wed_pkg::OFF_FIRST_STATUS) begin
      r = {2'b00, wed_pkg::IDX_FIRST};
    end else if (a == wed_pkg::OFF_SECOND_STATUS) begin
      r = {2'b00, wed_pkg::IDX_SECOND};
    end else if (a == wed_pkg::OFF_HOST_STATUS) begin
      r = {2'b00, wed_pkg::IDX_HOST};
    end else if (a == wed_pkg::OFF_FOURTH_STATUS) begin
      r = {2'b00, wed_pkg::IDX_FOURTH};
    end else if (a == wed_pkg::OFF_FIFTH_STATUS) begin
      r = {2'b00, wed_pkg::IDX_FIFTH};
    end else if (a == wed_pkg::OFF_SIXTH_STATUS) begin
      r = {2'b00, wed_pkg::IDX_SIXTH};
    end else if (a == wed_pkg::OFF_FAN_STATUS) begin
      r = {2'b00, wed_pkg::IDX_FAN};
    end else if (a >= wed_pkg::OFF_MASK_BASE && a < wed_pkg::OFF_ANY_EDGE_BASE) begin
      r = {2'b01, 3'(a - wed_pkg::OFF_MASK_BASE)};
    end else if (a >= wed_pkg::OFF_ANY_EDGE_BASE && a < wed_pkg::OFF_POLARITY_BASE) begin
      r = {2'b10, 3'(a - wed_pkg::OFF_ANY_EDGE_BASE)};
    end else if (a >= wed_pkg::OFF_POLARITY_BASE && a < wed_pkg::OFF_SLEEP_CTRL) begin
      r = {2'b10, 3'(3'h3 + 3'(a - wed_pkg::OFF_POLARITY_BASE))};
    end else if (a == wed_pkg::OFF_SLEEP_CTRL) begin
      r = 5'h18;
    end
    return r;
  endfunction

  // Reset release through two flops
  // Every flop then leaves reset on one edge, whatever the pin timing
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Configuration and status state
  logic [wed_pkg::DATA_W-1:0] status [wed_pkg::NUM_STATUS];
  logic [wed_pkg::DATA_W-1:0] mask [wed_pkg::NUM_STATUS];
  logic [NR-1:0]              any_edge_cfg;
  logic [NR-1:0]              polarity_cfg;
  logic [wed_pkg::DATA_W-1:0] next_status [wed_pkg::NUM_STATUS];
  logic [wed_pkg::DATA_W-1:0] next_mask [wed_pkg::NUM_STATUS];
  logic [NR-1:0]              next_any_edge_cfg;
  logic [NR-1:0]              next_polarity_cfg;
  logic [wed_pkg::DATA_W-1:0] next_rdata;
  wed_pkg::wed_sleep_e        sleep_state;
  wed_pkg::wed_sleep_e        next_sleep_state;

  logic [4:0] wr_sel;
  logic [4:0] rd_sel;

  assign wr_sel = decode(reg_addr);
  assign rd_sel = wr_sel;

  // Alternate function activity still counts as pin activity
  logic [NG-1:0] gpio_level;
  assign gpio_level = (gpio_alt_sel & gpio_alt_in) | (~gpio_alt_sel & gpio_pins);

  // Fixed-sense sources: internal pulses, second infrared and fan detectors rise, pins fall or any
  logic [NE-1:0] fixed_sample;
  logic [NE-1:0] fixed_any;
  logic [NE-1:0] fixed_rise;
  logic [NE-1:0] fixed_hit;

  assign fixed_sample = {fan_speed_two_low, fan_speed_one_low, floppy_parallel_detect,
                         1'b0, infrared_receive_pin, ring_indicator_pin,
                         two_wire_bus_two_data, two_wire_bus_one_data,
                         second_infrared_detect, 2'b00,
                         power_control_wake, power_enable_wake, power_status_wake,
                         hibernation_timer_wake, clock_alarm_wake};
  // Bits: 0 alarm,1 hib,2-4 power,5-6 spare,7 ir2,8-9 bus,10 ring,11 ir,12 spare,
  // 13 floppy,14 fan1,15 fan2
  assign fixed_any = 16'h2000;
  assign fixed_rise = 16'hc09f;

  wed_edge_det #(.WIDTH(NE)) u_fixed_edges (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .sample   (fixed_sample),
    .any_edge (fixed_any),
    .rise_sel (fixed_rise),
    .hit      (fixed_hit)
  );

  // Level pins: IN3 and each key line fall only, host gpios and other inputs any edge
  // Key lines are watched one by one so a held key cannot hide a second press
  localparam int NP = NL + 16;
  localparam logic [NP-1:0] PIN_ANY = 24'h00fff7;
  localparam logic [NP-1:0] PIN_RISE = 24'h000000;

  logic [NP-1:0] pin_hit;
  logic [NL-1:0] in_hit;
  logic [7:0]    key_hit;
  logic [7:0]    host_hit;

  wed_edge_det #(.WIDTH(NP)) u_input_edges (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .sample   ({key_scan_inputs, host_gpio_pins, general_inputs}),
    .any_edge (PIN_ANY),
    .rise_sel (PIN_RISE),
    .hit      (pin_hit)
  );

  assign in_hit = pin_hit[NL-1:0];
  assign host_hit = pin_hit[NL+7:NL];
  assign key_hit = pin_hit[NP-1:NL+8];

  // Every one of the 22 gpios has a detector and feeds a status bit
  logic [NG-1:0] gpio_hit;
  logic [NG-1:0] g;

  wed_edge_det #(.WIDTH(NG)) u_gpio_edges (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .sample   (gpio_level),
    .any_edge (any_edge_cfg[NG-1:0]),
    .rise_sel (polarity_cfg[NG-1:0]),
    .hit      (gpio_hit)
  );

  // Configuration bits above the last gpio are stored but steer no pin
  assign g = gpio_hit;

  // Raw event vectors per status register
  logic [wed_pkg::DATA_W-1:0] ev [wed_pkg::NUM_STATUS];

  always_comb begin
    for (int k = 0; k < wed_pkg::NUM_STATUS; k++) begin
      ev[k] = '0;
    end
    ev[wed_pkg::IDX_GENERAL][wed_pkg::B_GPIO3] = g[3];
    ev[wed_pkg::IDX_FIRST][wed_pkg::B_BUS_TWO] = fixed_hit[9];
    ev[wed_pkg::IDX_FIRST][wed_pkg::B_BUS_ONE] = fixed_hit[8];
    ev[wed_pkg::IDX_FIRST][wed_pkg::B_PWR_STATUS] = fixed_hit[2];
    ev[wed_pkg::IDX_FIRST][wed_pkg::B_PWR_ENABLE] = fixed_hit[3];
    ev[wed_pkg::IDX_FIRST][wed_pkg::B_PWR_CONTROL] = fixed_hit[4];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_ALARM] = fixed_hit[0];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_ANY_KEY] = (|key_hit) | in_hit[7];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_HIB_IR] = fixed_hit[1] | fixed_hit[11];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_GEN_WAKEUP] = in_hit[3];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_IN1] = in_hit[1];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_IN0_IN2] = in_hit[0] | in_hit[2];
    ev[wed_pkg::IDX_SECOND][wed_pkg::B_RING] = fixed_hit[10];
    ev[wed_pkg::IDX_HOST] = host_hit;
    ev[wed_pkg::IDX_FOURTH] = {g[4], g[7], in_hit[6], g[2], g[1], g[0], in_hit[5], in_hit[4]};
    ev[wed_pkg::IDX_FIFTH] = {g[13], g[12], g[11], g[10], g[9], g[8] | fixed_hit[7],
                              g[6], g[5]};
    ev[wed_pkg::IDX_SIXTH] = {g[18], g[21], g[20], g[19], g[17], g[16], g[15], g[14]};
    ev[wed_pkg::IDX_FAN][wed_pkg::B_FAN_ONE] = fixed_hit[14];
    ev[wed_pkg::IDX_FAN][wed_pkg::B_FAN_TWO] = fixed_hit[15];
    ev[wed_pkg::IDX_FAN][wed_pkg::B_FLOPPY] = fixed_hit[13];
  end

  // Unmasked pending events, any source class
  // Combinational, so a wake costs no extra cycle
  logic any_unmasked;

  always_comb begin
    any_unmasked = 1'b0;
    for (int k = 0; k < wed_pkg::NUM_STATUS; k++) begin
      any_unmasked = any_unmasked | (|(status[k] & ~mask[k]));
    end
  end

  // Status, mask and edge configuration update
  always_comb begin
    logic [wed_pkg::DATA_W-1:0] clr;
    clr = '0;
    for (int k = 0; k < wed_pkg::NUM_STATUS; k++) begin
      clr = (reg_wr && wr_sel == {2'b00, 3'(k)}) ? reg_wdata : 8'h00;
      // Write one clears; a new event in the same cycle wins
      next_status[k] = (status[k] & ~clr) | ev[k];
      next_mask[k] = (reg_wr && wr_sel == {2'b01, 3'(k)}) ? reg_wdata : mask[k];
    end
    next_any_edge_cfg = any_edge_cfg;
    next_polarity_cfg = polarity_cfg;
    // Edge configuration bytes, low byte first
    if (reg_wr) begin
      if (wr_sel == 5'h10) begin
        next_any_edge_cfg[7:0] = reg_wdata;
      end else if (wr_sel == 5'h11) begin
        next_any_edge_cfg[15:8] = reg_wdata;
      end else if (wr_sel == 5'h12) begin
        next_any_edge_cfg[23:16] = reg_wdata;
      end else if (wr_sel == 5'h13) begin
        next_polarity_cfg[7:0] = reg_wdata;
      end else if (wr_sel == 5'h14) begin
        next_polarity_cfg[15:8] = reg_wdata;
      end else if (wr_sel == 5'h15) begin
        next_polarity_cfg[23:16] = reg_wdata;
      end
    end
  end

  // Masks reset to all ones so nothing wakes before firmware opts in
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < wed_pkg::NUM_STATUS; k++) begin
        status[k] <= wed_pkg::RST_STATUS;
        mask[k] <= wed_pkg::RST_MASK;
      end
      any_edge_cfg <= {3{wed_pkg::RST_ANY_EDGE}};
      polarity_cfg <= {3{wed_pkg::RST_POLARITY}};
    end else begin
      for (int k = 0; k < wed_pkg::NUM_STATUS; k++) begin
        status[k] <= next_status[k];
        mask[k] <= next_mask[k];
      end
      any_edge_cfg <= next_any_edge_cfg;
      polarity_cfg <= next_polarity_cfg;
    end
  end

  // Sleep sequencing
  // Only bits 0 and 1 of a control write act; the rest are ignored
  logic ctrl_wr;
  assign ctrl_wr = reg_wr && wr_sel == 5'h18;

  always_comb begin
    next_sleep_state = sleep_state;
    case (sleep_state)
      wed_pkg::WED_AWAKE: begin
        if (ctrl_wr && reg_wdata[wed_pkg::CTRL_SLEEP_BIT]) begin
          next_sleep_state = wed_pkg::WED_ASLEEP;
        end
      end
      wed_pkg::WED_ASLEEP: begin
        // Masked sources leave the processor halted
        if (any_unmasked) begin
          next_sleep_state = wed_pkg::WED_WAKING;
        end
      end
      wed_pkg::WED_WAKING: begin
        // Oscillator runs until firmware has moved to its main clock
        if (ctrl_wr && reg_wdata[wed_pkg::CTRL_OSC_OFF_BIT]) begin
          next_sleep_state = wed_pkg::WED_AWAKE;
        end
      end
      default: begin
        next_sleep_state = wed_pkg::WED_AWAKE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_state <= wed_pkg::WED_AWAKE;
    end else begin
      sleep_state <= next_sleep_state;
    end
  end

  assign cpu_sleeping = sleep_state == wed_pkg::WED_ASLEEP;
  assign ring_osc_en = sleep_state == wed_pkg::WED_WAKING;
  assign wake_pending = any_unmasked;

  // Read path, data valid the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (rd_sel[4:3] == 2'b00) begin
        next_rdata = status[rd_sel[2:0]];
      end else if (rd_sel[4:3] == 2'b01) begin
        next_rdata = mask[rd_sel[2:0]];
      end else if (rd_sel == 5'h10) begin
        next_rdata = any_edge_cfg[7:0];
      end else if (rd_sel == 5'h11) begin
        next_rdata = any_edge_cfg[15:8];
      end else if (rd_sel == 5'h12) begin
        next_rdata = any_edge_cfg[23:16];
      end else if (rd_sel == 5'h13) begin
        next_rdata = polarity_cfg[7:0];
      end else if (rd_sel == 5'h14) begin
        next_rdata = polarity_cfg[15:8];
      end else if (rd_sel == 5'h15) begin
        next_rdata = polarity_cfg[23:16];
      end else if (rd_sel == 5'h18) begin
        next_rdata = {5'h00, any_unmasked, ring_osc_en, cpu_sleeping};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule
